// File: plc_ctrl.sv
// loop multiplier, range and lock-change control with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module plc_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [plc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [plc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analog lock indicator
  input wire logic lock_in,
  // system state, same clock
  input wire logic stop_mode,
  input wire logic oscillator_in_stop_enable,
  input wire logic break_active,
  input wire logic break_clear_enable,
  // clock generator controls
  output plc_pkg::plc_cgm_s clock_generator
);
  import plc_pkg::*;

  plc_state_s s;
  plc_state_s next_s;
  logic lock_sync;
  logic lock_toggle;
  logic [NREG-1:0] wr_hit;
  logic [NREG-1:0] rd_hit;
  logic flag_keep;
  logic stop_full;

  // one-hot register select; all zero means unmapped
  function automatic logic [NREG-1:0] reg_hit(
    input logic [ADDR_W-1:0] a);
    logic [NREG-1:0] h;
    h = '0;
    h[HIT_CTRL] = (a == OFF_CTRL);
    h[HIT_BWC] = (a == OFF_BWC);
    h[HIT_MULH] = (a == OFF_MULH);
    h[HIT_MULL] = (a == OFF_MULL);
    h[HIT_RANGE] = (a == OFF_RANGE);
    return h;
  endfunction : reg_hit

  plc_lock_detect u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .lock_async(lock_in),
    .lock_sync(lock_sync),
    .lock_toggle(lock_toggle)
  );

  assign wr_hit = reg_hit(awaddr);
  assign rd_hit = reg_hit(araddr);
  // protection bits carry no meaning here
  // a break without clear enable stops control reads clearing the flag
  assign flag_keep = break_active && !break_clear_enable;
  assign stop_full = stop_mode && !oscillator_in_stop_enable;

  always_comb begin
    next_s = s;
    case (s.bus)
      BUS_IDLE: begin
        if (awvalid && wvalid) begin
          next_s.awready = 1'b1;
          next_s.wready = 1'b1;
          next_s.bus = BUS_WACC;
        end else if (arvalid) begin
          next_s.arready = 1'b1;
          next_s.bus = BUS_RACC;
        end
      end
      BUS_WACC: begin
        next_s.awready = 1'b0;
        next_s.wready = 1'b0;
        next_s.bvalid = 1'b1;
        // refused protected writes still answer OKAY
        next_s.bresp = (wr_hit == '0) ? RESP_SLVERR : RESP_OKAY;
        next_s.bus = BUS_WRESP;
        if (wstrb[0]) begin
          if (wr_hit[HIT_CTRL]) begin
            if (s.regs.auto_bw) begin
              next_s.regs.ie = wdata[CTRL_IE];
            end
            if (!s.regs.en) begin
              next_s.regs.vpr = wdata[VPR_HI:VPR_LO];
            end
            // loop cannot drop while it drives the base clock
            next_s.regs.en = wdata[CTRL_EN] | s.regs.base_clock_select;
            // two writes needed: enable first, then select
            next_s.regs.base_clock_select = wdata[CTRL_BCS] & s.regs.en;
          end
          if (wr_hit[HIT_BWC]) begin
            next_s.regs.auto_bw = wdata[BWC_AUTO];
          end
          if (wr_hit[HIT_MULH] && !s.regs.en) begin
            next_s.regs.mulh = wdata[MULH_HI:0];
          end
          if (wr_hit[HIT_MULL] && !s.regs.en) begin
            next_s.regs.mull = wdata[7:0];
          end
          if (wr_hit[HIT_RANGE] && !s.regs.en) begin
            next_s.regs.range = wdata[7:0];
          end
        end
      end
      BUS_WRESP: begin
        if (bready) begin
          next_s.bvalid = 1'b0;
          next_s.bus = BUS_IDLE;
        end
      end
      BUS_RACC: begin
        next_s.arready = 1'b0;
        next_s.rvalid = 1'b1;
        next_s.rresp = (rd_hit == '0) ? RESP_SLVERR : RESP_OKAY;
        next_s.rdata = '0;
        if (rd_hit[HIT_CTRL]) begin
          next_s.rdata[CTRL_IE] = s.regs.ie;
          next_s.rdata[CTRL_FLAG] = s.regs.flag & s.regs.auto_bw;
          next_s.rdata[CTRL_EN] = s.regs.en;
          next_s.rdata[CTRL_BCS] = s.regs.base_clock_select;
          next_s.rdata[VPR_HI:VPR_LO] = s.regs.vpr;
          if (!flag_keep) begin
            next_s.regs.flag = 1'b0;
          end
        end
        if (rd_hit[HIT_BWC]) begin
          next_s.rdata[BWC_AUTO] = s.regs.auto_bw;
          next_s.rdata[BWC_LOCK] = lock_sync & s.regs.auto_bw;
        end
        if (rd_hit[HIT_MULH]) begin
          next_s.rdata[MULH_HI:0] = s.regs.mulh;
        end
        if (rd_hit[HIT_MULL]) begin
          next_s.rdata[7:0] = s.regs.mull;
        end
        if (rd_hit[HIT_RANGE]) begin
          next_s.rdata[7:0] = s.regs.range;
        end
        next_s.bus = BUS_RRESP;
      end
      BUS_RRESP: begin
        if (rready) begin
          next_s.rvalid = 1'b0;
          next_s.bus = BUS_IDLE;
        end
      end
      default: begin
        next_s.bus = BUS_IDLE;
        next_s.awready = 1'b0;
        next_s.wready = 1'b0;
        next_s.arready = 1'b0;
        next_s.bvalid = 1'b0;
        next_s.rvalid = 1'b0;
      end
    endcase
    // interrupt enable bit only writable in automatic mode
    if (!next_s.regs.auto_bw) begin
      next_s.regs.ie = 1'b0;
    end
    if (next_s.regs.range == RANGE_OFF) begin
      next_s.regs.en = 1'b0;
      next_s.regs.base_clock_select = 1'b0;
    end
    if (!next_s.regs.en) begin
      next_s.regs.base_clock_select = 1'b0;
    end
    // set wins over a read clear in the same cycle
    if (s.regs.auto_bw && lock_toggle) begin
      next_s.regs.flag = 1'b1;
    end
    // wait mode has no input here: nothing changes on it
    next_s.clock_generator.loop_run = next_s.regs.en && !stop_mode;
    next_s.clock_generator.osc_run = !stop_full;
    next_s.clock_generator.base_clk_en = !stop_full;
    next_s.clock_generator.vco_sel = next_s.regs.base_clock_select;
    next_s.clock_generator.irq = next_s.regs.auto_bw && next_s.regs.ie &&
                     next_s.regs.flag && !stop_full;
    next_s.clock_generator.fb_div = {next_s.regs.mulh, next_s.regs.mull};
    if (next_s.clock_generator.fb_div == DIV_ZERO) begin
      next_s.clock_generator.fb_div = DIV_MIN;
    end
    next_s.clock_generator.range_l = next_s.regs.range;
    next_s.clock_generator.range_e = next_s.regs.vpr;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign clock_generator = s.clock_generator;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_mull_guard;
    (s.bus == BUS_WACC) && s.regs.en |=> $stable(s.regs.mull);
  endproperty
  a_mull_guard: assert property (p_mull_guard)
    else $error("multiplier low byte changed while loop on");

  property p_range_guard;
    (s.bus == BUS_WACC) && s.regs.en |=> $stable(s.regs.range);
  endproperty
  a_range_guard: assert property (p_range_guard)
    else $error("range register changed while loop on");

  property p_mull_write;
    (s.bus == BUS_WACC) && !s.regs.en && wr_hit[HIT_MULL] && wstrb[0]
      |=> s.regs.mull == $past(wdata[7:0]);
  endproperty
  a_mull_write: assert property (p_mull_write)
    else $error("multiplier low byte write lost");

  property p_div_zero;
    ##1 ({s.regs.mulh, s.regs.mull} == DIV_ZERO) |-> s.clock_generator.fb_div == DIV_MIN;
  endproperty
  a_div_zero: assert property (p_div_zero)
    else $error("zero multiplier not driven as one");

  property p_reset_vals;
    $rose(aresetn) |-> s.regs.mull == MULL_RST && s.regs.range == RANGE_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("multiplier or range reset value wrong");

  property p_range_off;
    s.regs.range == RANGE_OFF |-> !s.regs.en && !s.clock_generator.vco_sel;
  endproperty
  a_range_off: assert property (p_range_off)
    else $error("zero range left loop or select on");

  property p_bcs_needs_en;
    s.regs.base_clock_select |-> s.regs.en && s.regs.range != RANGE_OFF;
  endproperty
  a_bcs_needs_en: assert property (p_bcs_needs_en)
    else $error("base clock select set without loop");

  property p_flag_set;
    s.regs.auto_bw && lock_toggle |=> s.regs.flag ##1 1'b1;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("lock toggle did not set flag");

  property p_irq_cause;
    s.clock_generator.irq |-> $past(s.regs.ie) || s.regs.ie;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt raised without enable");

  property p_flag_no_ie;
    s.regs.auto_bw && !s.regs.ie && lock_toggle && (s.bus != BUS_WACC)
      |=> s.regs.flag && !s.clock_generator.irq;
  endproperty
  a_flag_no_ie: assert property (p_flag_no_ie)
    else $error("flag not set with interrupts disabled");

  property p_manual_mask;
    (s.bus == BUS_RACC) && !s.regs.auto_bw
      && (rd_hit[HIT_CTRL] || rd_hit[HIT_BWC])
      |=> !s.rdata[CTRL_FLAG] && !s.clock_generator.irq;
  endproperty
  a_manual_mask: assert property (p_manual_mask)
    else $error("manual mode flag or interrupt visible");

  property p_stop_full;
    stop_mode && !oscillator_in_stop_enable
      |=> !s.clock_generator.osc_run && !s.clock_generator.base_clk_en && !s.clock_generator.irq
          && !s.clock_generator.loop_run;
  endproperty
  a_stop_full: assert property (p_stop_full)
    else $error("full stop left an output running");

  property p_stop_osc;
    stop_mode && oscillator_in_stop_enable
      |=> s.clock_generator.osc_run && !s.clock_generator.loop_run;
  endproperty
  a_stop_osc: assert property (p_stop_osc)
    else $error("stop with oscillator option wrong");

  property p_read_clear;
    (s.bus == BUS_RACC) && rd_hit[HIT_CTRL] && !flag_keep
      && !(s.regs.auto_bw && lock_toggle) |=> !s.regs.flag;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("control read did not clear flag");

  property p_break_keep;
    flag_keep && s.regs.flag |=> s.regs.flag;
  endproperty
  a_break_keep: assert property (p_break_keep)
    else $error("flag lost during protected break");

  property p_refused_ok;
    (s.bus == BUS_WACC) && s.regs.en && wr_hit[HIT_RANGE]
      |=> s.bvalid && s.bresp == RESP_OKAY;
  endproperty
  a_refused_ok: assert property (p_refused_ok)
    else $error("refused write did not answer OKAY");

  property p_read_answer;
    (s.bus == BUS_IDLE) && arvalid && !(awvalid && wvalid)
      |=> s.arready ##1 s.rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered in two cycles");
endmodule : plc_ctrl
`default_nettype wire

// File: plc_pkg.sv
// constants, types and reset state of the loop multiplier/lock control
package plc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_BWC = 8'h04;
  localparam logic [7:0] OFF_MULH = 8'h08;
  localparam logic [7:0] OFF_MULL = 8'h0C;
  localparam logic [7:0] OFF_RANGE = 8'h10;
  localparam int NREG = 5;
  localparam int HIT_CTRL = 0;
  localparam int HIT_BWC = 1;
  localparam int HIT_MULH = 2;
  localparam int HIT_MULL = 3;
  localparam int HIT_RANGE = 4;
  localparam int CTRL_IE = 7;
  localparam int CTRL_FLAG = 6;
  localparam int CTRL_EN = 5;
  localparam int CTRL_BCS = 4;
  localparam int VPR_HI = 1;
  localparam int VPR_LO = 0;
  localparam int BWC_AUTO = 7;
  localparam int BWC_LOCK = 6;
  localparam int MULH_HI = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] MULL_RST = 8'h40;
  localparam logic [3:0] MULH_RST = 4'h0;
  localparam logic [7:0] RANGE_RST = 8'h40;
  localparam logic [7:0] RANGE_OFF = 8'h00;
  localparam logic [11:0] DIV_ZERO = 12'h000;
  localparam logic [11:0] DIV_MIN = 12'h001;
  localparam logic [11:0] DIV_RST = 12'h040;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'h01,
    BUS_WACC = 5'h02,
    BUS_WRESP = 5'h04,
    BUS_RACC = 5'h08,
    BUS_RRESP = 5'h10
  } plc_bus_e;

  typedef struct packed {
    logic ie;
    logic flag;
    logic en;
    logic base_clock_select;
    logic [1:0] vpr;
    logic auto_bw;
    logic [3:0] mulh;
    logic [7:0] mull;
    logic [7:0] range;
  } plc_regs_s;

  typedef struct packed {
    logic loop_run;
    logic osc_run;
    logic base_clk_en;
    logic vco_sel;
    logic irq;
    logic [11:0] fb_div;
    logic [7:0] range_l;
    logic [1:0] range_e;
  } plc_cgm_s;

  typedef struct packed {
    plc_bus_e bus;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    plc_regs_s regs;
    plc_cgm_s clock_generator;
  } plc_state_s;

  localparam plc_state_s STATE_RST = '{
    bus: BUS_IDLE, awready: 1'b0, wready: 1'b0, bvalid: 1'b0,
    bresp: RESP_OKAY, arready: 1'b0, rvalid: 1'b0,
    rdata: 32'h0000_0000, rresp: RESP_OKAY,
    regs: '{ie: 1'b0, flag: 1'b0, en: 1'b1, base_clock_select: 1'b0, vpr: 2'h0,
            auto_bw: 1'b0, mulh: MULH_RST, mull: MULL_RST,
            range: RANGE_RST},
    clock_generator: '{loop_run: 1'b1, osc_run: 1'b1, base_clk_en: 1'b1,
           vco_sel: 1'b0, irq: 1'b0, fb_div: DIV_RST,
           range_l: RANGE_RST, range_e: 2'h0}
  };
endpackage : plc_pkg

// File: plc_lock_detect.sv
// lock indicator synchroniser and toggle detector
`timescale 1ns/1ps
`default_nettype none
module plc_lock_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // analog lock indicator
  input wire logic lock_async,
  // synchronised level and change pulse
  output logic lock_sync,
  output logic lock_toggle
);
  import plc_pkg::*;

  typedef struct packed {
    logic [SYNC_STAGES-1:0] sync;
    logic prev;
    logic toggle;
  } plc_det_s;

  plc_det_s s;
  plc_det_s next_s;
  wire logic [SYNC_STAGES-1:0] sync_d;

  // each stage only feeds the following one
  generate
    for (genvar i = 0; i < SYNC_STAGES; i++) begin : g_sync
      if (i == 0) begin : g_first
        assign sync_d[i] = lock_async;
      end else begin : g_rest
        assign sync_d[i] = s.sync[i-1];
      end
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.sync = sync_d;
    next_s.prev = s.sync[SYNC_STAGES-1];
    next_s.toggle = s.sync[SYNC_STAGES-1] ^ s.prev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lock_sync = s.prev;
  assign lock_toggle = s.toggle;
endmodule : plc_lock_detect
`default_nettype wire

// File: plc_ctrl_tb.sv
// self-checking bench for the loop multiplier, range and lock-change control
`timescale 1ns/1ps
`default_nettype none
module plc_ctrl_tb;
  import plc_pkg::*;

  logic aclk;
  logic aresetn;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic lock_in, stop_mode, osc_stop_en, brk, brk_clr;
  plc_cgm_s clock_generator;
  logic [31:0] rd_v;
  logic [1:0] rsp;
  int n_errors;
  int n_checks;

  plc_ctrl dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .lock_in(lock_in), .stop_mode(stop_mode),
    .oscillator_in_stop_enable(osc_stop_en),
    .break_active(brk), .break_clear_enable(brk_clr),
    .clock_generator(clock_generator)
  );

  always #10 aclk = ~aclk;

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] got,
                     input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // master holds each channel until its own ready edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic ad, wd;
    int n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {24'h000000, d};
    bready <= 1'b1;
    while (!(ad && wd) && n < 100) begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    chk("wr_timeout", {31'h0, n >= 100}, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (arready !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    chk("rd_timeout", {31'h0, n >= 100}, 32'h0);
  endtask : rd

  task automatic wchk(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, rsp);
    chk("bresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask : wchk

  task automatic rchk(input string name, input logic [7:0] a,
                      input logic [7:0] exp);
    rd(a, rd_v, rsp);
    chk(name, rd_v, {24'h000000, exp});
  endtask : rchk

  // lock level held long enough for the two-flop sync to see it
  task automatic toggle_lock;
    @(posedge aclk);
    lock_in <= ~lock_in;
    repeat (8) @(posedge aclk);
  endtask : toggle_lock

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    awprot = 3'h0;
    arprot = 3'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    {lock_in, stop_mode, osc_stop_en, brk, brk_clr} = 5'h00;
    n_errors = 0;
    n_checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("mull_rst", OFF_MULL, 8'h40);
    rchk("range_rst", OFF_RANGE, 8'h40);
    rchk("ctrl_rst", OFF_CTRL, 8'h20);
    rchk("mulh_rst", OFF_MULH, 8'h00);
    chk("fb_div_rst", {20'h0, clock_generator.fb_div}, {20'h0, DIV_RST});
    chk("range_l_rst", {24'h0, clock_generator.range_l}, 32'h0000_0040);
    // loop on: both registers refuse writes but answer OKAY
    wchk(OFF_MULL, 8'h12);
    rchk("mull_prot", OFF_MULL, 8'h40);
    wchk(OFF_RANGE, 8'h33);
    rchk("range_prot", OFF_RANGE, 8'h40);
    wchk(OFF_CTRL, 8'h00);
    wchk(OFF_MULL, 8'h00);
    repeat (3) @(posedge aclk);
    chk("fb_div_zero", {20'h0, clock_generator.fb_div}, {20'h0, DIV_MIN});
    wchk(OFF_MULL, 8'hA5);
    rchk("mull_rw", OFF_MULL, 8'hA5);
    repeat (3) @(posedge aclk);
    chk("fb_div", {20'h0, clock_generator.fb_div}, 32'h0000_00A5);
    wchk(OFF_RANGE, 8'h55);
    rchk("range_rw", OFF_RANGE, 8'h55);
    repeat (3) @(posedge aclk);
    chk("range_l", {24'h0, clock_generator.range_l}, 32'h0000_0055);
    // zero range keeps the loop off and the crystal path selected
    wchk(OFF_RANGE, RANGE_OFF);
    wchk(OFF_CTRL, 8'h30);
    rchk("ctrl_range0", OFF_CTRL, 8'h00);
    repeat (3) @(posedge aclk);
    chk("loop_run_r0", {31'h0, clock_generator.loop_run}, 32'h0);
    chk("vco_sel_r0", {31'h0, clock_generator.vco_sel}, 32'h0);
    wchk(OFF_RANGE, 8'h40);
    wchk(OFF_CTRL, 8'h12);
    rchk("ctrl_bcs_off", OFF_CTRL, 8'h02);
    chk("range_e", {30'h0, clock_generator.range_e}, 32'h0000_0002);
    wchk(OFF_CTRL, 8'h20);
    wchk(OFF_CTRL, 8'h30);
    rchk("ctrl_bcs_unlk", OFF_CTRL, 8'h30);
    repeat (4) @(posedge aclk);
    chk("vco_sel", {31'h0, clock_generator.vco_sel}, 32'h1);
    // manual bandwidth: toggles stay invisible
    toggle_lock;
    chk("irq_man", {31'h0, clock_generator.irq}, 32'h0);
    rchk("ctrl_man", OFF_CTRL, 8'h30);
    rchk("bwc_man", OFF_BWC, 8'h00);
    wchk(OFF_BWC, 8'h80);
    rchk("bwc_auto", OFF_BWC, 8'hC0);
    wchk(OFF_CTRL, 8'hB0);
    toggle_lock;
    chk("irq_en", {31'h0, clock_generator.irq}, 32'h1);
    rchk("flag_fall", OFF_CTRL, 8'hF0);
    rchk("flag_clr", OFF_CTRL, 8'hB0);
    wchk(OFF_CTRL, 8'h30);
    toggle_lock;
    chk("irq_masked", {31'h0, clock_generator.irq}, 32'h0);
    rchk("flag_noie", OFF_CTRL, 8'h70);
    // break state with and without clear permission
    brk <= 1'b1;
    toggle_lock;
    rchk("brk_keep1", OFF_CTRL, 8'h70);
    rchk("brk_keep2", OFF_CTRL, 8'h70);
    brk_clr <= 1'b1;
    rchk("brk_clr", OFF_CTRL, 8'h70);
    @(posedge aclk);
    brk <= 1'b0;
    brk_clr <= 1'b0;
    rchk("brk_after", OFF_CTRL, 8'h30);
    // stop: oscillator kept, then full stop with irq pending
    wchk(OFF_CTRL, 8'hB0);
    toggle_lock;
    chk("irq_pre_stop", {31'h0, clock_generator.irq}, 32'h1);
    stop_mode <= 1'b1;
    osc_stop_en <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("loop_stop", {31'h0, clock_generator.loop_run}, 32'h0);
    chk("osc_stop_on", {31'h0, clock_generator.osc_run}, 32'h1);
    osc_stop_en <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("osc_stop_off", {31'h0, clock_generator.osc_run}, 32'h0);
    chk("base_clk_stop", {31'h0, clock_generator.base_clk_en}, 32'h0);
    chk("irq_stop", {31'h0, clock_generator.irq}, 32'h0);
    chk("loop_full_stop", {31'h0, clock_generator.loop_run}, 32'h0);
    stop_mode <= 1'b0;
    // unmapped place
    wr(8'h14, 8'h5A, rsp);
    chk("bresp_unmap", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd(8'h14, rd_v, rsp);
    chk("rresp_unmap", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("rdata_unmap", rd_v, 32'h0000_0000);
    test_done();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    test_done();
  end
endmodule : plc_ctrl_tb
`default_nettype wire
